// >>> hw/bchu_top.sv
// configuration header upper slice of the bridge: windows, interrupt regs, bridge control
module bchu_top (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] CFG_ADDR_I,
    input wire logic CFG_WR_I,
    input wire logic CFG_RD_I,
    input wire logic [3:0] CFG_BE_I,
    input wire logic [31:0] CFG_WDATA_I,
    output logic [31:0] CFG_RDATA_O,
    output logic CFG_RVALID_O,
    input wire logic IO_REQ_I,
    input wire logic [31:0] IO_ADDR_I,
    output logic IO_FWD_VALID_O,
    output logic IO_FWD_O,
    output logic [31:0] PREF_LIMIT_HIGH_O,
    input wire logic [3:0] SEC_INTX_I,
    output logic [3:0] PRI_INTX_O,
    input wire logic PCI_CONV_MODE_I,
    input wire logic AER_PRESENT_I,
    input wire logic AER_FATAL_SEL_I,
    input wire logic DISCARD_EXPIRE_I,
    input wire logic ERR_MSG_ACK_I,
    output logic ERR_MSG_REQ_O,
    output logic ERR_MSG_FATAL_O
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] prefetch_limit_high_bits;
        logic [15:0] io_low_bound_high_bits;
        logic [15:0] io_high_bound_high_bits;
        logic [7:0] int_line;
        logic discard_expiry_error_enable;
        logic [31:0] rdata;
        logic rvalid;
        logic [3:0] intx;
    } bchu_top_state_t;

    bchu_top_state_t st_r;
    bchu_top_state_t st_nxt;
    logic [5:0] dw_index;
    logic [15:0] bctl_view;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // byte-lane merge of a 16-bit field under two byte enables
    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0] be
    );
        logic [15:0] res;
        res = old_v;
        if (be[0])
        begin
            res[7:0] = new_v[7:0];
        end
        if (be[1])
        begin
            res[15:8] = new_v[15:8];
        end
        merge16 = res;
    endfunction

    // dword index of a byte address
    function automatic logic [5:0] dw_of(input logic [7:0] byte_addr);
        dw_of = byte_addr[7:bchu_pkg::DW_ADDR_LSB];
    endfunction

    assign dw_index = dw_of(CFG_ADDR_I);

    // only bit 11 is held here; the other control bits live elsewhere
    always_comb
    begin
        bctl_view = bchu_pkg::BRIDGE_CTL_RST;
        bctl_view[bchu_pkg::DISCARD_EXPIRY_ERROR_ENABLE_BIT] = st_r.discard_expiry_error_enable;
    end

    // ------------------------------------------------------------------
    // configuration access
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;

        // write path; reads in the same cycle return the old value
        if (CFG_WR_I)
        begin
            if (dw_index == dw_of(bchu_pkg::OFF_PREF_LIMIT_HI))
            begin
                st_nxt.prefetch_limit_high_bits[15:0] = merge16(
                    st_r.prefetch_limit_high_bits[15:0],
                    CFG_WDATA_I[15:0],
                    CFG_BE_I[1:0]);
                st_nxt.prefetch_limit_high_bits[31:16] = merge16(
                    st_r.prefetch_limit_high_bits[31:16],
                    CFG_WDATA_I[31:16],
                    CFG_BE_I[3:2]);
            end
            else if (dw_index == dw_of(bchu_pkg::OFF_IO_HI))
            begin
                st_nxt.io_low_bound_high_bits = merge16(
                    st_r.io_low_bound_high_bits,
                    CFG_WDATA_I[15:0],
                    CFG_BE_I[1:0]);
                st_nxt.io_high_bound_high_bits = merge16(
                    st_r.io_high_bound_high_bits,
                    CFG_WDATA_I[31:16],
                    CFG_BE_I[3:2]);
            end
            else if (dw_index == dw_of(bchu_pkg::OFF_INTR_BCTL))
            begin
                if (CFG_BE_I[0])
                begin
                    st_nxt.int_line = CFG_WDATA_I[7:0];
                end
                // byte 1 is the hardwired pin value and byte 2 holds no storage
                if (CFG_BE_I[3])
                begin
                    st_nxt.discard_expiry_error_enable =
                        CFG_WDATA_I[bchu_pkg::HI_HALF_LSB + bchu_pkg::DISCARD_EXPIRY_ERROR_ENABLE_BIT];
                end
            end
            // the capability pointer dword and unmapped dwords take no write
        end

        // read path
        st_nxt.rvalid = CFG_RD_I;
        st_nxt.rdata = bchu_pkg::RDATA_UNMAPPED;
        if (CFG_RD_I)
        begin
            if (dw_index == dw_of(bchu_pkg::OFF_PREF_LIMIT_HI))
            begin
                st_nxt.rdata = st_r.prefetch_limit_high_bits;
            end
            else if (dw_index == dw_of(bchu_pkg::OFF_IO_HI))
            begin
                st_nxt.rdata = {st_r.io_high_bound_high_bits,
                                st_r.io_low_bound_high_bits};
            end
            else if (dw_index == dw_of(bchu_pkg::OFF_CAP_PTR))
            begin
                st_nxt.rdata = {24'h000000, bchu_pkg::CAP_PTR_VAL};
            end
            else if (dw_index == dw_of(bchu_pkg::OFF_INTR_BCTL))
            begin
                st_nxt.rdata = {bctl_view, bchu_pkg::INT_PIN_VAL, st_r.int_line};
            end
        end

        // interrupts are forwarded untouched; the line register does not gate them
        st_nxt.intx = SEC_INTX_I;
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            st_r.prefetch_limit_high_bits <= bchu_pkg::PREF_LIMIT_HI_RST;
            st_r.io_low_bound_high_bits <= bchu_pkg::IO_BASE_HI_RST;
            st_r.io_high_bound_high_bits <= bchu_pkg::IO_LIMIT_HI_RST;
            st_r.int_line <= bchu_pkg::INT_LINE_RST;
            st_r.discard_expiry_error_enable <= bchu_pkg::BRIDGE_CTL_RST[bchu_pkg::DISCARD_EXPIRY_ERROR_ENABLE_BIT];
            st_r.rdata <= bchu_pkg::RDATA_UNMAPPED;
            st_r.rvalid <= 1'b0;
            st_r.intx <= 4'h0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // i/o window check
    // ------------------------------------------------------------------
    bchu_iowin u_iowin (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .base_hi_i(st_r.io_low_bound_high_bits),
        .limit_hi_i(st_r.io_high_bound_high_bits),
        .req_i(IO_REQ_I),
        .addr_i(IO_ADDR_I),
        .valid_o(IO_FWD_VALID_O),
        .hit_o(IO_FWD_O)
    );

    // ------------------------------------------------------------------
    // discard-timer error message
    // ------------------------------------------------------------------
    bchu_errmsg u_errmsg (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .enable_i(st_r.discard_expiry_error_enable),
        .conv_mode_i(PCI_CONV_MODE_I),
        .aer_present_i(AER_PRESENT_I),
        .fatal_sel_i(AER_FATAL_SEL_I),
        .expire_i(DISCARD_EXPIRE_I),
        .ack_i(ERR_MSG_ACK_I),
        .req_o(ERR_MSG_REQ_O),
        .fatal_o(ERR_MSG_FATAL_O)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign CFG_RDATA_O = st_r.rdata;
    assign CFG_RVALID_O = st_r.rvalid;
    assign PREF_LIMIT_HIGH_O = st_r.prefetch_limit_high_bits;
    assign PRI_INTX_O = st_r.intx;

endmodule

// >>> hw/bchu_pkg.sv
// shared constants for the bridge configuration header upper slice
package bchu_pkg;

    // ------------------------------------------------------------------
    // configuration dword offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PREF_LIMIT_HI = 8'h2C;
    localparam logic [7:0] OFF_IO_HI = 8'h30;
    localparam logic [7:0] OFF_CAP_PTR = 8'h34;
    localparam logic [7:0] OFF_INTR_BCTL = 8'h3C;

    // byte offsets of the sub-dword registers
    localparam logic [7:0] BOFF_IO_BASE_HI = 8'h30;
    localparam logic [7:0] BOFF_IO_LIMIT_HI = 8'h32;
    localparam logic [7:0] BOFF_INT_LINE = 8'h3C;
    localparam logic [7:0] BOFF_INT_PIN = 8'h3D;
    localparam logic [7:0] BOFF_BRIDGE_CTL = 8'h3E;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int DW_ADDR_LSB = 2;
    localparam int HI_HALF_LSB = 16;
    localparam int INT_PIN_LSB = 8;
    localparam int DISCARD_EXPIRY_ERROR_ENABLE_BIT = 11;
    localparam int IO_ADDR_MAP_LSB = 20;
    localparam int IO_HI_USED_W = 12;

    // ------------------------------------------------------------------
    // reset and hardwired values
    // ------------------------------------------------------------------
    localparam logic [31:0] PREF_LIMIT_HI_RST = 32'h0000_0000;
    localparam logic [15:0] IO_BASE_HI_RST = 16'h0000;
    localparam logic [15:0] IO_LIMIT_HI_RST = 16'h0000;
    localparam logic [7:0] CAP_PTR_VAL = 8'h50;
    localparam logic [7:0] INT_LINE_RST = 8'hFF;
    localparam logic [7:0] INT_PIN_VAL = 8'h00;
    localparam logic [15:0] BRIDGE_CTL_RST = 16'h0000;
    localparam logic [19:0] IO_LOW_FILL_BASE = 20'h00000;
    localparam logic [19:0] IO_LOW_FILL_LIMIT = 20'hFFFFF;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    // ------------------------------------------------------------------
    // error message sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BCHU_ERR_IDLE = 2'b01,
        BCHU_ERR_SEND = 2'b10
    } bchu_err_state_t;

endpackage

// >>> hw/bchu_iowin.sv
// i/o window decoder: assembles the forwarding bounds and checks an address
module bchu_iowin (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] base_hi_i,
    input wire logic [15:0] limit_hi_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    output logic valid_o,
    output logic hit_o
);

    typedef struct packed {
        logic valid;
        logic hit;
    } bchu_iowin_state_t;

    bchu_iowin_state_t st_r;
    bchu_iowin_state_t st_nxt;
    logic [31:0] base_addr;
    logic [31:0] limit_addr;

    // ------------------------------------------------------------------
    // bound assembly
    // ------------------------------------------------------------------
    function automatic logic [31:0] io_bound(input logic [15:0] hi, input logic [19:0] fill);
        io_bound = {hi[bchu_pkg::IO_HI_USED_W-1:0], fill};
    endfunction

    assign base_addr = io_bound(base_hi_i, bchu_pkg::IO_LOW_FILL_BASE);
    assign limit_addr = io_bound(limit_hi_i, bchu_pkg::IO_LOW_FILL_LIMIT);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.valid = req_i;
        // both bounds inclusive; an inverted window never matches
        st_nxt.hit = req_i && (addr_i >= base_addr) && (addr_i <= limit_addr);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign valid_o = st_r.valid;
    assign hit_o = st_r.hit;

endmodule

// >>> hw/bchu_errmsg.sv
// discard-timer error message sequencer toward the primary side
module bchu_errmsg (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic conv_mode_i,
    input wire logic aer_present_i,
    input wire logic fatal_sel_i,
    input wire logic expire_i,
    input wire logic ack_i,
    output logic req_o,
    output logic fatal_o
);

    typedef struct packed {
        bchu_pkg::bchu_err_state_t fsm;
        logic pending;
        logic fatal;
    } bchu_errmsg_state_t;

    bchu_errmsg_state_t st_r;
    bchu_errmsg_state_t st_nxt;
    logic trigger;
    logic sev_fatal;

    // ------------------------------------------------------------------
    // trigger and severity
    // ------------------------------------------------------------------
    assign trigger = expire_i && enable_i && conv_mode_i;
    // without error reporting support the severity input is ignored
    assign sev_fatal = aer_present_i && fatal_sel_i;

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r.fsm)
            bchu_pkg::BCHU_ERR_IDLE:
            begin
                if (trigger)
                begin
                    st_nxt.fsm = bchu_pkg::BCHU_ERR_SEND;
                    st_nxt.fatal = sev_fatal;
                end
            end
            bchu_pkg::BCHU_ERR_SEND:
            begin
                if (ack_i)
                begin
                    // one expiry seen while a message is outstanding is queued; further ones merge into it
                    if (st_r.pending || trigger)
                    begin
                        st_nxt.pending = 1'b0;
                        st_nxt.fatal = sev_fatal;
                    end
                    else
                    begin
                        st_nxt.fsm = bchu_pkg::BCHU_ERR_IDLE;
                    end
                end
                else if (trigger)
                begin
                    st_nxt.pending = 1'b1;
                end
            end
            default:
            begin
                st_nxt.fsm = bchu_pkg::BCHU_ERR_IDLE;
                st_nxt.pending = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r.fsm <= bchu_pkg::BCHU_ERR_IDLE;
            st_r.pending <= 1'b0;
            st_r.fatal <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign req_o = (st_r.fsm == bchu_pkg::BCHU_ERR_SEND);
    assign fatal_o = st_r.fatal;

endmodule

// >>> dv/bchu_top_sva.sv
// assertion checker for the bridge configuration header upper slice
module bchu_top_sva (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] CFG_ADDR_I,
    input wire logic CFG_WR_I,
    input wire logic CFG_RD_I,
    input wire logic [3:0] CFG_BE_I,
    input wire logic [31:0] CFG_WDATA_I,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic CFG_RVALID_O,
    input wire logic IO_REQ_I,
    input wire logic IO_FWD_VALID_O,
    input wire logic IO_FWD_O,
    input wire logic [31:0] PREF_LIMIT_HIGH_O,
    input wire logic [3:0] SEC_INTX_I,
    input wire logic [3:0] PRI_INTX_O,
    input wire logic PCI_CONV_MODE_I,
    input wire logic AER_PRESENT_I,
    input wire logic AER_FATAL_SEL_I,
    input wire logic DISCARD_EXPIRE_I,
    input wire logic ERR_MSG_ACK_I,
    input wire logic ERR_MSG_REQ_O,
    input wire logic ERR_MSG_FATAL_O
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    AST_RD_ANSWER: assert property (CFG_RD_I |=> CFG_RVALID_O)
        else $error("read not answered after one cycle");
    AST_RD_IDLE: assert property (!CFG_RD_I |=> !CFG_RVALID_O && CFG_RDATA_O == 32'h0)
        else $error("read data without a read");
    AST_CAP_PTR: assert property (CFG_RD_I && CFG_ADDR_I[7:2] == 6'h0D |=> CFG_RDATA_O == 32'h50)
        else $error("capability pointer not 50h");
    AST_RSVD_ZERO: assert property (CFG_RD_I && CFG_ADDR_I[7:2] == 6'h0F
        |=> CFG_RDATA_O[31:28] == 4'h0 && CFG_RDATA_O[26:8] == 19'h0)
        else $error("reserved or pin bits not zero");
    AST_INTX_FOLLOW: assert property (!$past(RST_I) |-> PRI_INTX_O == $past(SEC_INTX_I))
        else $error("interrupts not passed through");
    AST_IO_ANSWER: assert property (IO_REQ_I |=> IO_FWD_VALID_O)
        else $error("window check not answered");
    AST_IO_QUIET: assert property (!IO_REQ_I |=> !IO_FWD_VALID_O && !IO_FWD_O)
        else $error("forward without request");
    AST_PREF_COPY: assert property (CFG_WR_I && CFG_ADDR_I[7:2] == 6'h0B && CFG_BE_I == 4'hF
        ##1 !CFG_WR_I |=> PREF_LIMIT_HIGH_O == $past(CFG_WDATA_I, 2))
        else $error("prefetch limit copy wrong");
    AST_MSG_HOLD: assert property (ERR_MSG_REQ_O && !ERR_MSG_ACK_I
        |=> ERR_MSG_REQ_O && $stable(ERR_MSG_FATAL_O))
        else $error("message request dropped before ack");
    AST_MSG_OFF: assert property (!ERR_MSG_REQ_O && !(DISCARD_EXPIRE_I && PCI_CONV_MODE_I)
        |=> !ERR_MSG_REQ_O)
        else $error("message without qualified expiry");
    AST_MSG_SEV: assert property ($rose(ERR_MSG_REQ_O)
        |-> ERR_MSG_FATAL_O == ($past(AER_PRESENT_I) && $past(AER_FATAL_SEL_I)))
        else $error("message severity wrong");

    COV_FATAL_ACK: cover property (ERR_MSG_REQ_O && ERR_MSG_ACK_I && ERR_MSG_FATAL_O);
    COV_IO_HIT: cover property (IO_FWD_VALID_O && IO_FWD_O);
    COV_CTL_BIT: cover property (CFG_RVALID_O && CFG_RDATA_O[27]);
endmodule

// >>> dv/bchu_msg_sink.sv
// primary-side model that accepts discard-timer error messages
module bchu_msg_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic fatal_i,
    input wire logic [3:0] delay_i,
    output logic ack_o,
    output logic [7:0] n_msg_o,
    output logic sev_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_r;

    // ------------------------------------------------------------
    // acceptor: one ack pulse after delay_i + 1 cycles of standing request
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            wait_r <= 4'h0;
            n_msg_o <= 8'h00;
            sev_o <= 1'b0;
        end
        else if (ack_o || !req_i)
        begin
            // gap after ack: the request may stay up for a queued message
            ack_o <= 1'b0;
            wait_r <= 4'h0;
        end
        else if (wait_r >= delay_i)
        begin
            ack_o <= 1'b1;
            n_msg_o <= n_msg_o + 8'h01;
            sev_o <= fatal_i;
        end
        else
            wait_r <= wait_r + 4'h1;
    end
endmodule

// >>> dv/bchu_top_tb.sv
// self-checking testbench for the bridge configuration header upper slice
module bchu_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [7:0] a;
        logic [3:0] be;
        logic [31:0] wd;
        logic [31:0] exp;
    } bchu_row_t;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic [7:0] CFG_ADDR_I = 8'h00;
    logic CFG_WR_I = 1'b0;
    logic CFG_RD_I = 1'b0;
    logic [3:0] CFG_BE_I = 4'h0;
    logic [31:0] CFG_WDATA_I = 32'h0;
    logic IO_REQ_I = 1'b0;
    logic [31:0] IO_ADDR_I = 32'h0;
    logic [3:0] SEC_INTX_I = 4'h0;
    logic PCI_CONV_MODE_I = 1'b0;
    logic AER_PRESENT_I = 1'b0;
    logic AER_FATAL_SEL_I = 1'b0;
    logic DISCARD_EXPIRE_I = 1'b0;
    logic [3:0] sink_delay = 4'h0;
    logic ERR_MSG_ACK_I, CFG_RVALID_O, IO_FWD_VALID_O, IO_FWD_O, ERR_MSG_REQ_O, ERR_MSG_FATAL_O;
    logic [31:0] CFG_RDATA_O, PREF_LIMIT_HIGH_O, rd;
    logic [3:0] PRI_INTX_O;
    logic [7:0] n_msg;
    logic sev;
    int bad_count = 0;
    int n_tests = 0;

    // first three rows read reset values: writes with no byte enabled
    localparam bchu_row_t ROWS [11] = '{
        '{8'h2C, 4'h0, 32'hFFFF_FFFF, 32'h0000_0000},
        '{8'h30, 4'h0, 32'hFFFF_FFFF, 32'h0000_0000},
        '{8'h3C, 4'h0, 32'hFFFF_FFFF, 32'h0000_00FF},
        '{8'h2C, 4'hF, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
        '{8'h30, 4'hF, 32'h1234_5678, 32'h1234_5678},
        '{8'h32, 4'h5, 32'hFFFF_FFFF, 32'h12FF_56FF},
        '{8'h34, 4'hF, 32'hFFFF_FFFF, 32'h0000_0050},
        '{8'h3C, 4'hF, 32'hFFFF_FFFF, 32'h0800_00FF},
        '{8'h3E, 4'h1, 32'h0000_0012, 32'h0800_0012},
        '{8'h3C, 4'h8, 32'h0000_0000, 32'h0000_0012},
        '{8'h38, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}
    };

    always #20 CLK_I = ~CLK_I;

    bchu_top uut (.CLK_I(CLK_I), .RST_I(RST_I), .CFG_ADDR_I(CFG_ADDR_I), .CFG_WR_I(CFG_WR_I),
        .CFG_RD_I(CFG_RD_I), .CFG_BE_I(CFG_BE_I), .CFG_WDATA_I(CFG_WDATA_I),
        .CFG_RDATA_O(CFG_RDATA_O), .CFG_RVALID_O(CFG_RVALID_O), .IO_REQ_I(IO_REQ_I),
        .IO_ADDR_I(IO_ADDR_I), .IO_FWD_VALID_O(IO_FWD_VALID_O), .IO_FWD_O(IO_FWD_O),
        .PREF_LIMIT_HIGH_O(PREF_LIMIT_HIGH_O), .SEC_INTX_I(SEC_INTX_I), .PRI_INTX_O(PRI_INTX_O),
        .PCI_CONV_MODE_I(PCI_CONV_MODE_I), .AER_PRESENT_I(AER_PRESENT_I),
        .AER_FATAL_SEL_I(AER_FATAL_SEL_I), .DISCARD_EXPIRE_I(DISCARD_EXPIRE_I),
        .ERR_MSG_ACK_I(ERR_MSG_ACK_I), .ERR_MSG_REQ_O(ERR_MSG_REQ_O),
        .ERR_MSG_FATAL_O(ERR_MSG_FATAL_O));

    bchu_msg_sink sink (.clk_i(CLK_I), .rst_i(RST_I), .req_i(ERR_MSG_REQ_O),
        .fatal_i(ERR_MSG_FATAL_O), .delay_i(sink_delay), .ack_o(ERR_MSG_ACK_I),
        .n_msg_o(n_msg), .sev_o(sev));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic cyc;
        @(posedge CLK_I);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        CFG_ADDR_I = a;
        CFG_BE_I = be;
        CFG_WDATA_I = d;
        CFG_WR_I = 1'b1;
        cyc();
        CFG_WR_I = 1'b0;
    endtask

    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
        CFG_ADDR_I = a;
        CFG_RD_I = 1'b1;
        cyc();
        CFG_RD_I = 1'b0;
        chk(32'(CFG_RVALID_O), 32'h1);
        d = CFG_RDATA_O;
    endtask

    // request stays up between calls so checks run back to back
    task automatic io_chk(input logic [31:0] a, input logic hit);
        IO_ADDR_I = a;
        IO_REQ_I = 1'b1;
        cyc();
        chk({30'h0, IO_FWD_VALID_O, IO_FWD_O}, {30'h0, 1'b1, hit});
    endtask

    task automatic expire(input int gap);
        DISCARD_EXPIRE_I = 1'b1;
        cyc();
        DISCARD_EXPIRE_I = 1'b0;
        repeat (gap) cyc();
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) cyc();
        RST_I = 1'b0;
        foreach (ROWS[i])
        begin
            cfg_wr(ROWS[i].a, ROWS[i].be, ROWS[i].wd);
            cfg_rd(ROWS[i].a, rd);
            chk(rd, ROWS[i].exp);
        end
        chk(PREF_LIMIT_HIGH_O, 32'hA5A5_5A5A);
        $display("register table done");
        // top nibbles set on purpose: they must not take part in matching
        cfg_wr(8'h30, 4'hF, 32'hF003_F001);
        io_chk(32'h000F_FFFF, 1'b0);
        io_chk(32'h0010_0000, 1'b1);
        io_chk(32'h003F_FFFF, 1'b1);
        io_chk(32'h0040_0000, 1'b0);
        IO_REQ_I = 1'b0;
        cfg_wr(8'h30, 4'hF, 32'h0003_0005);
        io_chk(32'h0040_0000, 1'b0);
        IO_REQ_I = 1'b0;
        $display("io window done");
        SEC_INTX_I = 4'hA;
        cyc();
        chk(32'(PRI_INTX_O), 32'hA);
        SEC_INTX_I = 4'h5;
        cfg_rd(8'h3C, rd);
        chk(32'(PRI_INTX_O), 32'h5);
        chk(rd, 32'h0000_0012);
        $display("interrupt pass-through done");
        PCI_CONV_MODE_I = 1'b1;
        expire(4);
        chk(32'(n_msg), 32'h0);
        cfg_wr(8'h3E, 4'h8, 32'h0800_0000);
        PCI_CONV_MODE_I = 1'b0;
        expire(4);
        chk(32'(n_msg), 32'h0);
        PCI_CONV_MODE_I = 1'b1;
        AER_FATAL_SEL_I = 1'b1;
        expire(6);
        chk({23'h0, n_msg, sev}, {23'h0, 8'h01, 1'b0});
        AER_PRESENT_I = 1'b1;
        sink_delay = 4'h6;
        expire(1);
        expire(1);
        expire(20);
        chk({23'h0, n_msg, sev}, {23'h0, 8'h03, 1'b1});
        chk(32'(ERR_MSG_REQ_O), 32'h0);
        $display("error message done");
        RST_I = 1'b1;
        repeat (2) cyc();
        RST_I = 1'b0;
        cfg_rd(8'h3C, rd);
        chk(rd, 32'h0000_00FF);
        cfg_rd(8'h30, rd);
        chk(rd, 32'h0000_0000);
        $display("second reset done");
        complete_run();
    end

    initial
    begin
        repeat (3000) @(posedge CLK_I);
        bad_count++;
        complete_run();
    end
endmodule

bind bchu_top bchu_top_sva chk_i (.CLK_I(CLK_I), .RST_I(RST_I), .CFG_ADDR_I(CFG_ADDR_I),
    .CFG_WR_I(CFG_WR_I), .CFG_RD_I(CFG_RD_I), .CFG_BE_I(CFG_BE_I), .CFG_WDATA_I(CFG_WDATA_I),
    .CFG_RDATA_O(CFG_RDATA_O), .CFG_RVALID_O(CFG_RVALID_O), .IO_REQ_I(IO_REQ_I),
    .IO_FWD_VALID_O(IO_FWD_VALID_O), .IO_FWD_O(IO_FWD_O), .PREF_LIMIT_HIGH_O(PREF_LIMIT_HIGH_O),
    .SEC_INTX_I(SEC_INTX_I), .PRI_INTX_O(PRI_INTX_O), .PCI_CONV_MODE_I(PCI_CONV_MODE_I),
    .AER_PRESENT_I(AER_PRESENT_I), .AER_FATAL_SEL_I(AER_FATAL_SEL_I),
    .DISCARD_EXPIRE_I(DISCARD_EXPIRE_I), .ERR_MSG_ACK_I(ERR_MSG_ACK_I),
    .ERR_MSG_REQ_O(ERR_MSG_REQ_O), .ERR_MSG_FATAL_O(ERR_MSG_FATAL_O));
